// ===== pkg/cos_pkg.sv
package cos_pkg;

   // Aux output function codes
   typedef enum logic [2:0]
   {
      COS_AUX_OFF  = 3'h0,
      COS_AUX_OVR  = 3'h1,
      COS_AUX_DIV1 = 3'h3,
      COS_AUX_DIV2 = 3'h2,
      COS_AUX_DIV4 = 3'h6
   } cos_aux_e;

   // Pin synchroniser depth
   localparam int unsigned SYNC_STAGES = 3;

   // Select and pin codes
   localparam logic [1:0] AUX_CODE_OFF  = 2'h0;
   localparam logic [1:0] AUX_CODE_DIV1 = 2'h1;
   localparam logic [1:0] AUX_CODE_DIV2 = 2'h2;
   localparam logic [1:0] AUX_CODE_DIV4 = 2'h3;

   // Trigger clock mode that repeats the timestamp input
   localparam logic [1:0] TRIG_MODE_TIMESTAMP = 2'h3;

   // Divide ratios
   localparam int unsigned RATIO_DIV1 = 1;
   localparam int unsigned RATIO_DIV2 = 2;
   localparam int unsigned RATIO_DIV4 = 4;

   // Reset values
   localparam logic      RST_OUT        = 1'b0;
   localparam logic      RST_REF_SEL    = 1'b0;
   localparam logic      RST_GATE       = 1'b0;
   localparam cos_aux_e  RST_AUX_FUNC   = COS_AUX_OFF;
   localparam int unsigned RST_RATIO    = 1;
   localparam int unsigned RST_COUNT    = 0;

   // Pin vector layout
   localparam int unsigned PIN_PD    = 0;
   localparam int unsigned PIN_PLL   = 1;
   localparam int unsigned PIN_RSEL  = 2;
   localparam int unsigned PIN_CFG0  = 3;
   localparam int unsigned PIN_CFG1  = 4;
   localparam int unsigned PIN_DIFF  = 5;
   localparam int unsigned PIN_SE    = 6;
   localparam int unsigned PIN_TS    = 7;
   localparam int unsigned PIN_SER   = 8;
   localparam int unsigned PIN_COUNT = 9;

endpackage : cos_pkg

// ===== pkg/cos_div_if.sv
interface cos_div_if
#(
   parameter int W = 8
);
   logic         ref_level;
   logic [W-1:0] ratio;
   logic         clk_out;

   modport src
   (
      output ref_level,
      output ratio,
      input  clk_out
   );

   modport div
   (
      input  ref_level,
      input  ratio,
      output clk_out
   );
endinterface : cos_div_if

// ===== hdl/cos_pin_sync.sv
module cos_pin_sync
#(
   parameter int W = 1
)
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_pins,
   output logic      [W-1:0] o_pins
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;

   if (W < 1)
   begin : g_bad_w
      $error("cos_pin_sync: W must be at least 1");
   end

   // Three stage capture
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= i_pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a bit once stages two and three agree
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         out_q <= '0;
      else
         out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
   end

   assign o_pins = out_q;

endmodule : cos_pin_sync

// ===== hdl/cos_ref_divider.sv
module cos_ref_divider
#(
   parameter int W = 8
)
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   cos_div_if.div    bus
);

   logic         ref_prev_q;
   logic [W-1:0] ratio_q;
   logic [W-1:0] cnt_q;
   logic         out_q;
   logic         rise;
   logic [W-1:0] ratio_eff;

   if (W < 3)
   begin : g_bad_w
      $error("cos_ref_divider: W must be at least 3");
   end

   assign rise      = bus.ref_level && !ref_prev_q;
   assign ratio_eff = (bus.ratio == '0) ? W'(1) : bus.ratio;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ref_prev_q <= 1'b0;
      else
         ref_prev_q <= bus.ref_level;
   end

   // Count source edges, new ratio only at wrap
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q   <= W'(cos_pkg::RST_COUNT);
         ratio_q <= W'(cos_pkg::RST_RATIO);
      end
      else if (rise)
      begin
         if (cnt_q >= ratio_q - W'(1))
         begin
            cnt_q   <= '0;
            ratio_q <= ratio_eff;
         end
         else
         begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end

   // High while the count is below half the ratio (rounded down); ratio 1 follows the source level
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         out_q <= cos_pkg::RST_OUT;
      else if (ratio_q == W'(1))
         out_q <= bus.ref_level;
      else
         out_q <= (cnt_q < (ratio_q >> 1));
   end

   assign bus.clk_out = out_q;

   property p_div_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      !rise |=> $stable(cnt_q) && $stable(ratio_q);
   endproperty
   a_div_hold: assert property (p_div_hold)
      else $error("divider count moved without a source edge");

endmodule : cos_ref_divider

// ===== hdl/cos_clock_output_select.sv
module cos_clock_output_select
#(
   parameter int RX_DIV_W  = 8,
   parameter bit QUAD_PART = 1'b1
)
(
   input  wire logic                i_clk,
   input  wire logic                i_rst_n,
   input  wire logic                i_power_down_pin,
   input  wire logic                i_pll_enable_pin,
   input  wire logic                i_ref_input_select,
   input  wire logic [1:0]          i_clock_config_pins,
   input  wire logic                i_diff_ref_in,
   input  wire logic                i_single_ended_ref_in,
   input  wire logic                i_timestamp_in,
   input  wire logic                i_serdes_pll_clk,
   input  wire logic                i_ref_repeat_enable,
   input  wire logic                i_trigger_out_enable,
   input  wire logic [1:0]          i_trigger_out_mode,
   input  wire logic [RX_DIV_W-1:0] i_rx_div,
   input  wire logic                i_pin_override_enable,
   input  wire logic [1:0]          i_aux_c_select,
   input  wire logic [1:0]          i_aux_d_select,
   input  wire logic                i_overrange_flag_enable,
   input  wire logic                i_overrange_c,
   input  wire logic                i_overrange_d,
   output logic                     o_ref_repeat_out,
   output logic                     o_trigger_clock_out,
   output logic                     o_aux_clock_out_c,
   output logic                     o_aux_clock_out_d,
   output logic                     o_pll_active,
   output logic                     o_sampling_direct
);

   if (RX_DIV_W < 3)
   begin : g_bad_div_w
      $error("cos_clock_output_select: RX_DIV_W below 3");
   end

   logic [cos_pkg::PIN_COUNT-1:0] pins_raw;
   logic [cos_pkg::PIN_COUNT-1:0] pins_s;
   logic                          pd_s;
   logic                          pll_s;
   logic                          rsel_s;
   logic [1:0]                    cfg_s;
   logic                          diff_s;
   logic                          se_s;
   logic                          ts_s;
   logic                          ser_s;

   assign pins_raw[cos_pkg::PIN_PD]   = i_power_down_pin;
   assign pins_raw[cos_pkg::PIN_PLL]  = i_pll_enable_pin;
   assign pins_raw[cos_pkg::PIN_RSEL] = i_ref_input_select;
   assign pins_raw[cos_pkg::PIN_CFG0] = i_clock_config_pins[0];
   assign pins_raw[cos_pkg::PIN_CFG1] = i_clock_config_pins[1];
   assign pins_raw[cos_pkg::PIN_DIFF] = i_diff_ref_in;
   assign pins_raw[cos_pkg::PIN_SE]   = i_single_ended_ref_in;
   assign pins_raw[cos_pkg::PIN_TS]   = i_timestamp_in;
   assign pins_raw[cos_pkg::PIN_SER]  = i_serdes_pll_clk;

   cos_pin_sync
   #(
      .W (cos_pkg::PIN_COUNT)
   )
   cos_pin_sync_i
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pins  (pins_raw),
      .o_pins  (pins_s)
   );

   assign pd_s   = pins_s[cos_pkg::PIN_PD];
   assign pll_s  = pins_s[cos_pkg::PIN_PLL];
   assign rsel_s = pins_s[cos_pkg::PIN_RSEL];
   assign cfg_s  = {pins_s[cos_pkg::PIN_CFG1], pins_s[cos_pkg::PIN_CFG0]};
   assign diff_s = pins_s[cos_pkg::PIN_DIFF];
   assign se_s   = pins_s[cos_pkg::PIN_SE];
   assign ts_s   = pins_s[cos_pkg::PIN_TS];
   assign ser_s  = pins_s[cos_pkg::PIN_SER];

   // Map a nonzero code to its divide function
   function automatic cos_pkg::cos_aux_e code_to_div(input logic [1:0] code);
      case (code)
         cos_pkg::AUX_CODE_DIV1: code_to_div = cos_pkg::COS_AUX_DIV1;
         cos_pkg::AUX_CODE_DIV2: code_to_div = cos_pkg::COS_AUX_DIV2;
         cos_pkg::AUX_CODE_DIV4: code_to_div = cos_pkg::COS_AUX_DIV4;
         default:                code_to_div = cos_pkg::COS_AUX_OFF;
      endcase
   endfunction : code_to_div

   // Wanted function of one aux output
   function automatic cos_pkg::cos_aux_e aux_decode
   (
      input logic       is_d,
      input logic       pd,
      input logic       ovr_pin_en,
      input logic [1:0] pins,
      input logic [1:0] sel,
      input logic [1:0] c_sel,
      input logic       overrange_flag_enable
   );
      logic [1:0] code;
      cos_pkg::cos_aux_e idle;
      code = ovr_pin_en ? sel : pins;
      if (ovr_pin_en && is_d && (c_sel == cos_pkg::AUX_CODE_OFF))
         code = cos_pkg::AUX_CODE_OFF;
      idle = (overrange_flag_enable && QUAD_PART) ? cos_pkg::COS_AUX_OVR
                                   : cos_pkg::COS_AUX_OFF;
      if (pd)
         aux_decode = cos_pkg::COS_AUX_OFF;
      else if (code == cos_pkg::AUX_CODE_OFF)
         aux_decode = idle;
      else if (!ovr_pin_en && is_d)
         aux_decode = cos_pkg::COS_AUX_DIV1;
      else
         aux_decode = code_to_div(code);
   endfunction : aux_decode

   // Ratio for a divide function
   function automatic logic [RX_DIV_W-1:0] func_ratio
   (
      input cos_pkg::cos_aux_e f
   );
      case (f)
         cos_pkg::COS_AUX_DIV2: func_ratio = RX_DIV_W'(cos_pkg::RATIO_DIV2);
         cos_pkg::COS_AUX_DIV4: func_ratio = RX_DIV_W'(cos_pkg::RATIO_DIV4);
         default:               func_ratio = RX_DIV_W'(cos_pkg::RATIO_DIV1);
      endcase
   endfunction : func_ratio

   // Reference select, switched only while both inputs are low
   logic ref_sel_q;
   logic ref_lvl;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ref_sel_q <= cos_pkg::RST_REF_SEL;
      else if (!diff_s && !se_s)
         ref_sel_q <= rsel_s;
   end

   assign ref_lvl = ref_sel_q ? se_s : diff_s;

   // Loop status
   logic pll_q;
   logic direct_q;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pll_q    <= cos_pkg::RST_OUT;
         direct_q <= cos_pkg::RST_OUT;
      end
      else
      begin
         pll_q    <= pll_s;
         direct_q <= !pll_s;
      end
   end

   // Reference repeat gate, moved only while the reference is low
   logic ref_on;
   logic ref_en_q;
   logic ref_out_q;

   assign ref_on = pll_s && !pd_s && i_ref_repeat_enable;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ref_en_q <= cos_pkg::RST_GATE;
      else if (!ref_lvl)
         ref_en_q <= ref_on;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ref_out_q <= cos_pkg::RST_OUT;
      else
         ref_out_q <= ref_lvl && ref_en_q;
   end

   // Aux outputs C and D
   cos_pkg::cos_aux_e aux_want  [2];
   cos_pkg::cos_aux_e aux_func_q[2];
   logic              aux_out_q [2];
   logic              ovr_flag  [2];

   assign aux_want[0] = aux_decode(1'b0, pd_s, i_pin_override_enable,
                                   cfg_s, i_aux_c_select, i_aux_c_select,
                                   i_overrange_flag_enable);
   assign aux_want[1] = aux_decode(1'b1, pd_s, i_pin_override_enable,
                                   cfg_s, i_aux_d_select, i_aux_c_select,
                                   i_overrange_flag_enable);
   assign ovr_flag[0] = i_overrange_c;
   assign ovr_flag[1] = i_overrange_d;

   cos_div_if #(.W(RX_DIV_W)) aux_if[2] ();

   for (genvar g = 0; g < 2; g++)
   begin : g_aux
      logic old_quiet;
      logic new_quiet;

      assign aux_if[g].ref_level = ref_lvl;
      assign aux_if[g].ratio     = func_ratio(aux_want[g]);

      cos_ref_divider
      #(
         .W (RX_DIV_W)
      )
      cos_ref_divider_i
      (
         .i_clk   (i_clk),
         .i_rst_n (i_rst_n),
         .bus     (aux_if[g])
      );

      // Clock functions switch only in a low phase
      assign old_quiet = !aux_out_q[g] ||
         (aux_func_q[g] inside {cos_pkg::COS_AUX_OFF, cos_pkg::COS_AUX_OVR});
      assign new_quiet = !aux_if[g].clk_out ||
         (aux_want[g] inside {cos_pkg::COS_AUX_OFF, cos_pkg::COS_AUX_OVR});

      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
            aux_func_q[g] <= cos_pkg::RST_AUX_FUNC;
         else if (old_quiet && new_quiet)
            aux_func_q[g] <= aux_want[g];
      end

      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
         if (!i_rst_n)
            aux_out_q[g] <= cos_pkg::RST_OUT;
         else
         begin
            case (aux_func_q[g])
               cos_pkg::COS_AUX_OFF:  aux_out_q[g] <= 1'b0;
               cos_pkg::COS_AUX_OVR:  aux_out_q[g] <= ovr_flag[g];
               default:               aux_out_q[g] <= aux_if[g].clk_out;
            endcase
         end
      end
   end

   // Trigger clock output
   cos_div_if #(.W(RX_DIV_W)) trig_if ();
   logic trig_en_q;
   logic trig_ts_q;
   logic trig_out_q;
   logic trig_quiet;

   assign trig_if.ref_level = ser_s;
   assign trig_if.ratio     = i_rx_div;

   cos_ref_divider
   #(
      .W (RX_DIV_W)
   )
   cos_ref_divider_i
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .bus     (trig_if)
   );

   assign trig_quiet = !trig_out_q && !ts_s && !trig_if.clk_out;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trig_en_q <= cos_pkg::RST_GATE;
         trig_ts_q <= cos_pkg::RST_GATE;
      end
      else if (trig_quiet)
      begin
         trig_en_q <= i_trigger_out_enable;
         trig_ts_q <= (i_trigger_out_mode == cos_pkg::TRIG_MODE_TIMESTAMP);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         trig_out_q <= cos_pkg::RST_OUT;
      else if (!trig_en_q)
         trig_out_q <= 1'b0;
      else
         trig_out_q <= trig_ts_q ? ts_s : trig_if.clk_out;
   end

   assign o_ref_repeat_out    = ref_out_q;
   assign o_trigger_clock_out = trig_out_q;
   assign o_aux_clock_out_c   = aux_out_q[0];
   assign o_aux_clock_out_d   = aux_out_q[1];
   assign o_pll_active        = pll_q;
   assign o_sampling_direct   = direct_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_ref_stop;
      (pd_s || !pll_s) && !ref_lvl;
   endsequence
   sequence s_ref_start;
      ref_on && !ref_lvl;
   endsequence

   property p_ref_stop;
      s_ref_stop |=> !ref_en_q ##1 !o_ref_repeat_out;
   endproperty
   a_ref_stop: assert property (p_ref_stop)
      else $error("reference repeat kept driving after stop");

   property p_ref_start;
      s_ref_start |=> ref_en_q;
   endproperty
   a_ref_start: assert property (p_ref_start)
      else $error("reference repeat did not turn on with loop");

   property p_ref_sw_off;
      !i_ref_repeat_enable && !ref_lvl |=> !ref_en_q ##1 !o_ref_repeat_out;
   endproperty
   a_ref_sw_off: assert property (p_ref_sw_off)
      else $error("reference repeat ignored software disable");

   property p_ref_follow;
      ref_en_q && $stable(ref_sel_q) |=> o_ref_repeat_out ==
         $past(ref_sel_q ? se_s : diff_s);
   endproperty
   a_ref_follow: assert property (p_ref_follow)
      else $error("reference repeat not from selected input");

   property p_trig_off;
      !trig_en_q |=> !o_trigger_clock_out;
   endproperty
   a_trig_off: assert property (p_trig_off)
      else $error("trigger clock driven while disabled");

   property p_trig_ts;
      trig_en_q && trig_ts_q |=> o_trigger_clock_out == $past(ts_s);
   endproperty
   a_trig_ts: assert property (p_trig_ts)
      else $error("trigger clock not following timestamp");

   property p_aux_pd;
      pd_s |-> aux_want[0] == cos_pkg::COS_AUX_OFF &&
               aux_want[1] == cos_pkg::COS_AUX_OFF;
   endproperty
   a_aux_pd: assert property (p_aux_pd)
      else $error("aux output wanted during power-down");

   property p_aux_d_pins;
      !pd_s && !i_pin_override_enable && cfg_s != cos_pkg::AUX_CODE_OFF
         |-> aux_want[1] == cos_pkg::COS_AUX_DIV1;
   endproperty
   a_aux_d_pins: assert property (p_aux_d_pins)
      else $error("pin mode output D not undivided");

   property p_aux_d_gate;
      i_pin_override_enable && i_aux_c_select == cos_pkg::AUX_CODE_OFF
         |-> aux_want[1] inside {cos_pkg::COS_AUX_OFF, cos_pkg::COS_AUX_OVR};
   endproperty
   a_aux_d_gate: assert property (p_aux_d_gate)
      else $error("output D clock without output C select");

   property p_aux_override;
      !pd_s && i_pin_override_enable && i_aux_c_select ==
         cos_pkg::AUX_CODE_DIV4 |-> aux_want[0] == cos_pkg::COS_AUX_DIV4;
   endproperty
   a_aux_override: assert property (p_aux_override)
      else $error("override select not applied to output C");

   property p_aux_prio;
      !pd_s && !i_pin_override_enable && i_overrange_flag_enable &&
         cfg_s == cos_pkg::AUX_CODE_DIV2 |-> aux_want[0] ==
         cos_pkg::COS_AUX_DIV2;
   endproperty
   a_aux_prio: assert property (p_aux_prio)
      else $error("over-range beat a clock selection");

   property p_aux_glitch;
      $changed(aux_func_q[0]) && !($past(aux_func_q[0]) inside
         {cos_pkg::COS_AUX_OFF, cos_pkg::COS_AUX_OVR})
         |-> $past(!aux_out_q[0]);
   endproperty
   a_aux_glitch: assert property (p_aux_glitch)
      else $error("output C function switched while high");

   property p_aux_off;
      aux_func_q[0] == cos_pkg::COS_AUX_OFF |=> !o_aux_clock_out_c;
   endproperty
   a_aux_off: assert property (p_aux_off)
      else $error("output C driven while disabled");

endmodule : cos_clock_output_select

// ===== bench/cos_far_end.sv
module cos_far_end
#(
   parameter int DIFF_HALF = 8,
   parameter int SE_HALF   = 12,
   parameter int SER_HALF  = 2,
   parameter int TS_HALF   = 20
)
(
   input  wire logic i_clk,
   output logic      o_diff_ref,
   output logic      o_se_ref,
   output logic      o_ser_clk,
   output logic      o_timestamp
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt;

   initial
   begin
      cnt = 0;
      o_diff_ref = 1'b0;
      o_se_ref = 1'b0;
      o_ser_clk = 1'b0;
      o_timestamp = 1'b0;
   end

   // Free-running reference, serializer and trigger sources
   always @(negedge i_clk)
   begin
      cnt <= cnt + 1;
      o_diff_ref <= ((cnt / DIFF_HALF) % 2) == 1;
      o_se_ref <= ((cnt / SE_HALF) % 2) == 1;
      o_ser_clk <= ((cnt / SER_HALF) % 2) == 1;
      o_timestamp <= ((cnt / TS_HALF) % 2) == 1;
   end
endmodule : cos_far_end

// ===== bench/cos_clock_output_select_bench.sv
module cos_clock_output_select_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIM = 400;

   logic       clk;
   logic       rst_n;
   logic       pd;
   logic       pll_en;
   logic       ref_sel;
   logic [1:0] cfg;
   logic       diff_ref;
   logic       se_ref;
   logic       ts;
   logic       ser;
   logic       ref_en;
   logic       trig_en;
   logic [1:0] trig_mode;
   logic [7:0] rx_div;
   logic       ovr_pin;
   logic [1:0] c_sel;
   logic [1:0] d_sel;
   logic       overrange_flag_enable;
   logic       ovr_c;
   logic       ovr_d;
   logic       ref_out;
   logic       trig_out;
   logic       c_out;
   logic       d_out;
   logic       pll_act;
   logic       direct;
   logic [3:0] outs;
   int         n_fail;
   int         num_checks;

   assign outs = {d_out, c_out, trig_out, ref_out};

   cos_far_end cos_far_end_i
   (
      .i_clk       (clk),
      .o_diff_ref  (diff_ref),
      .o_se_ref    (se_ref),
      .o_ser_clk   (ser),
      .o_timestamp (ts)
   );

   cos_clock_output_select
   #(
      .RX_DIV_W  (8),
      .QUAD_PART (1'b1)
   )
   cos_clock_output_select_i
   (
      .i_clk                   (clk),
      .i_rst_n                 (rst_n),
      .i_power_down_pin        (pd),
      .i_pll_enable_pin        (pll_en),
      .i_ref_input_select      (ref_sel),
      .i_clock_config_pins     (cfg),
      .i_diff_ref_in           (diff_ref),
      .i_single_ended_ref_in   (se_ref),
      .i_timestamp_in          (ts),
      .i_serdes_pll_clk        (ser),
      .i_ref_repeat_enable     (ref_en),
      .i_trigger_out_enable    (trig_en),
      .i_trigger_out_mode      (trig_mode),
      .i_rx_div                (rx_div),
      .i_pin_override_enable   (ovr_pin),
      .i_aux_c_select          (c_sel),
      .i_aux_d_select          (d_sel),
      .i_overrange_flag_enable (overrange_flag_enable),
      .i_overrange_c           (ovr_c),
      .i_overrange_d           (ovr_d),
      .o_ref_repeat_out        (ref_out),
      .o_trigger_clock_out     (trig_out),
      .o_aux_clock_out_c       (c_out),
      .o_aux_clock_out_d       (d_out),
      .o_pll_active            (pll_act),
      .o_sampling_direct       (direct)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   task automatic settle();
      repeat (80) @(negedge clk);
   endtask : settle

   // Cycles to next rising edge of output k, LIM when none
   task automatic rise(input int k, output int n);
      logic prev;
      n = 0;
      prev = outs[k];
      while (n < LIM && !(outs[k] === 1'b1 && prev === 1'b0))
      begin
         prev = outs[k];
         @(posedge clk);
         #1;
         n++;
      end
      @(negedge clk);
   endtask : rise

   task automatic per(input int k, input int exp);
      int n;
      settle();
      rise(k, n);
      rise(k, n);
      rise(k, n);
      check(n, exp);
   endtask : per

   task automatic quiet(input int k);
      int n;
      settle();
      rise(k, n);
      check(n, LIM);
      check({31'h0, outs[k]}, 32'h0);
   endtask : quiet

   task automatic t_ref();
      per(0, 16);
      check({31'h0, pll_act}, 32'h1);
      check({31'h0, direct}, 32'h0);
      ref_sel = 1'b1;
      per(0, 24);
      ref_sel = 1'b0;
      ref_en = 1'b0;
      quiet(0);
      ref_en = 1'b1;
      per(0, 16);
      pd = 1'b1;
      quiet(0);
      pd = 1'b0;
      pll_en = 1'b0;
      quiet(0);
      check({31'h0, pll_act}, 32'h0);
      check({31'h0, direct}, 32'h1);
      pll_en = 1'b1;
   endtask : t_ref

   task automatic t_trig();
      quiet(1);
      trig_en = 1'b1;
      trig_mode = 2'h0;
      rx_div = 8'h03;
      per(1, 12);
      rx_div = 8'h05;
      per(1, 20);
      trig_mode = 2'h3;
      per(1, 40);
      trig_en = 1'b0;
      quiet(1);
   endtask : t_trig

   task automatic t_pins();
      for (int c = 1; c < 4; c++)
      begin
         cfg = c[1:0];
         per(2, 16 << (c - 1));
         per(3, 16);
      end
      cfg = 2'h0;
      quiet(2);
      quiet(3);
   endtask : t_pins

   task automatic t_regs();
      ovr_pin = 1'b1;
      for (int s = 1; s < 4; s++)
      begin
         c_sel = 2'h1;
         d_sel = s[1:0];
         per(3, 16 << (s - 1));
         c_sel = s[1:0];
         per(2, 16 << (s - 1));
      end
      cfg = 2'h3;
      c_sel = 2'h1;
      per(2, 16);
      c_sel = 2'h0;
      d_sel = 2'h1;
      quiet(3);
      quiet(2);
      ovr_pin = 1'b0;
      cfg = 2'h2;
      per(2, 32);
   endtask : t_regs

   task automatic t_flags();
      cfg = 2'h0;
      overrange_flag_enable = 1'b1;
      ovr_c = 1'b1;
      ovr_d = 1'b1;
      settle();
      check({31'h0, c_out}, 32'h1);
      check({31'h0, d_out}, 32'h1);
      ovr_c = 1'b0;
      ovr_d = 1'b0;
      settle();
      check({31'h0, c_out}, 32'h0);
      check({31'h0, d_out}, 32'h0);
      ovr_c = 1'b1;
      ovr_d = 1'b1;
      cfg = 2'h1;
      per(2, 16);
      per(3, 16);
      cfg = 2'h2;
      per(2, 32);
      pd = 1'b1;
      quiet(2);
      quiet(3);
      pd = 1'b0;
      per(2, 32);
      per(3, 16);
   endtask : t_flags

   initial
   begin
      #400000;
      n_fail++;
      final_report();
   end

   initial
   begin
      n_fail = 0;
      num_checks = 0;
      rst_n = 1'b0;
      pd = 1'b0;
      pll_en = 1'b1;
      ref_sel = 1'b0;
      cfg = 2'h0;
      ref_en = 1'b1;
      trig_en = 1'b0;
      trig_mode = 2'h0;
      rx_div = 8'h01;
      ovr_pin = 1'b0;
      c_sel = 2'h0;
      d_sel = 2'h0;
      overrange_flag_enable = 1'b0;
      ovr_c = 1'b0;
      ovr_d = 1'b0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_trig();
      t_ref();
      t_pins();
      t_regs();
      t_flags();
      final_report();
   end
endmodule : cos_clock_output_select_bench
